// File: hdl/mmc_cmd_edge.sv
// Arms on a zero command write and fires once on the next nonzero one.
`timescale 1ns/100ps
module mmc_cmd_edge (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Command writes
    input wire logic i_wr,
    input wire logic [31:0] i_data,
    // Result
    output logic o_fire,
    output logic [31:0] o_cmd,
    output logic o_armed
);
    logic take;

    assign take = i_wr && i_data != mmc_pkg::CMD_CLEAR && o_armed; // see R16

    // A repeated nonzero word finds the latch disarmed and is ignored.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_armed <= 1'b1;
            o_fire <= 1'b0;
            o_cmd <= '0;
        end else begin
            o_fire <= take;
            if (take) begin
                o_cmd <= i_data;
                o_armed <= 1'b0;
            end else if (i_wr && i_data == mmc_pkg::CMD_CLEAR) begin
                o_armed <= 1'b1; // see R13
            end
        end
    end

    rearm_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R13
        i_wr && i_data == mmc_pkg::CMD_CLEAR |=> o_armed)
        else $error("zero write did not re-arm");
    fire_once_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R16
        o_fire |-> !o_armed && $past(o_armed))
        else $error("command fired twice without re-arm");
endmodule : mmc_cmd_edge

// File: hdl/mmc_handler.sv
// Motor mode command handler: cyclic mapping, homing gate and commands.
`timescale 1ns/100ps
//
// Overview of operation
// (R1) Mode 0 passive, 1 velocity, 2 position.
// (R2) Position mode moves to requested position.
// (R3) Velocity, load, following error are readable.
// (R4) Error stops motor, cause in status.
// (R5) Status bits: 4 in position, 5/6 ramps.
// (R6) Modes 12,13,14,25,26 start homing.
// (R7) Homing blocks cyclic writes, reads continue.
// (R8) In-position bit marks homing complete.
// (R9) Leaving homing code resumes cyclic writes.
// (R10) Master maps mode into read and write.
// (R11) Command word triggers relative move.
// (R12) Master spaces offset, command, clear by cycles.
// (R13) Zero command write re-arms the interpreter.
// (R14) Object write 16/272 saves module/motor parameters.
// (R15) Up to eight mapped input and output words.
// (R16) Command acts once per zero-to-nonzero change.
module mmc_handler #(
    parameter int MAP_WORDS = 8,
    parameter logic [19:0] REL_OFFSET_ADDR = 20'h00007
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Slot mapping setup
    input wire logic i_map_wr,
    input wire logic i_map_out,
    input wire logic [$clog2(MAP_WORDS)-1:0] i_map_slot,
    input wire logic [19:0] i_map_addr,
    // Cyclic write words from the master
    input wire logic i_cw_valid,
    input wire logic [$clog2(MAP_WORDS)-1:0] i_cw_slot,
    input wire logic [31:0] i_cw_data,
    // Cyclic read words to the master
    input wire logic i_cr_req,
    input wire logic [$clog2(MAP_WORDS)-1:0] i_cr_slot,
    output logic o_cr_valid,
    output logic [31:0] o_cr_data,
    // Non-cyclic object writes
    input wire logic i_ac_wr,
    input wire logic [15:0] i_ac_obj,
    input wire logic [31:0] i_ac_data,
    // Motor state
    input wire logic [31:0] i_actual_position_value,
    input wire logic [31:0] i_actual_velocity_value,
    input wire logic [31:0] i_average_load,
    input wire logic [31:0] i_following_error,
    input wire logic [mmc_pkg::ERR_CAUSE_W-1:0] i_err_cause,
    input wire logic i_in_position,
    input wire logic i_accelerating,
    input wire logic i_decelerating,
    // Register writes forwarded to the motor
    output logic o_mot_wr_valid,
    output logic [19:0] o_mot_wr_addr,
    output logic [31:0] o_mot_wr_data,
    // Motion control
    output logic o_axle_energized,
    output logic o_error_stop,
    output logic [31:0] o_actual_mode,
    output logic [31:0] o_target_position_value,
    output logic [31:0] o_target_velocity_value,
    output logic [31:0] o_target_acceleration_value,
    output logic o_pos_move,
    output logic o_home_start,
    output logic o_homing,
    output logic o_rel_move,
    output logic [31:0] o_rel_offset,
    // Flash save requests
    output logic o_save_module,
    output logic o_save_motor
);
    localparam int SW = $clog2(MAP_WORDS);

    if (MAP_WORDS < 2 || MAP_WORDS > 8) begin : g_check
        $error("MAP_WORDS must lie between 2 and 8");
    end

    logic cw_vld_q, cr_vld_q, in_pos_q;
    logic [31:0] cw_data_q;
    logic [19:0] cw_addr, cr_addr;
    logic [31:0] mode_q, tpos_q, tvel_q, tacc_q, rel_off_q;
    mmc_pkg::mmc_home_type home_q, home_d;
    logic wr_mode, wr_home_code, wr_tpos, is_mcmd, blocked, fwd, err_active;
    logic cmd_fire, cmd_armed;
    logic [31:0] cmd_word, status_w, rd_val;

    // Output words use the write map, input words the read map.
    mmc_map_mem #(.DEPTH(MAP_WORDS), .AW(20)) u_wr_map (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_wr_en(i_map_wr && i_map_out),
        .i_wr_idx(i_map_slot),
        .i_wr_addr(i_map_addr),
        .i_rd_idx(i_cw_slot),
        .o_rd_addr(cw_addr)
    );
    mmc_map_mem #(.DEPTH(MAP_WORDS), .AW(20)) u_rd_map (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_wr_en(i_map_wr && !i_map_out),
        .i_wr_idx(i_map_slot),
        .i_wr_addr(i_map_addr),
        .i_rd_idx(i_cr_slot),
        .o_rd_addr(cr_addr)
    );

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cw_vld_q <= 1'b0;
            cw_data_q <= '0;
            cr_vld_q <= 1'b0;
            in_pos_q <= 1'b0;
        end else begin
            cw_vld_q <= i_cw_valid;
            cw_data_q <= i_cw_data;
            cr_vld_q <= i_cr_req;
            in_pos_q <= i_in_position;
        end
    end

    // Write decode once the slot address is known.
    assign wr_mode = cw_vld_q && cw_addr == mmc_pkg::REG_OPERATING_MODE;
    assign wr_tpos = cw_vld_q && cw_addr == mmc_pkg::REG_REQUESTED_POSITION;
    assign is_mcmd = cw_addr == mmc_pkg::REG_MODULE_COMMAND;
    assign wr_home_code = cw_data_q == mmc_pkg::MODE_HOME_TORQUE
        || cw_data_q == mmc_pkg::MODE_HOME_FWD
        || cw_data_q == mmc_pkg::MODE_HOME_FWD_BWD
        || cw_data_q == mmc_pkg::MODE_HOME_INDEX
        || cw_data_q == mmc_pkg::MODE_HOME_QUICK_INDEX; // see R6
    // After completion only a non-homing mode write gets through and releases the gate.
    assign blocked = home_q == mmc_pkg::HM_ACTIVE
        || (home_q == mmc_pkg::HM_DONE && !(wr_mode && !wr_home_code)); // see R7 see R9
    assign fwd = cw_vld_q && !is_mcmd && !blocked;
    assign err_active = |i_err_cause;

    // Completion needs a fresh in-position edge, since the bit may still be set
    // from the move before homing began.
    always_comb begin
        home_d = home_q;
        case (home_q)
            mmc_pkg::HM_IDLE: begin
                if (fwd && wr_mode && wr_home_code) begin
                    home_d = mmc_pkg::HM_ACTIVE; // see R6
                end
            end
            mmc_pkg::HM_ACTIVE: begin
                if (i_in_position && !in_pos_q) begin
                    home_d = mmc_pkg::HM_DONE; // see R8
                end
            end
            mmc_pkg::HM_DONE: begin
                if (fwd && wr_mode) begin
                    home_d = mmc_pkg::HM_IDLE; // see R9
                end
            end
            default: begin
                home_d = mmc_pkg::HM_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            home_q <= mmc_pkg::HM_IDLE;
        end else begin
            home_q <= home_d;
        end
    end

    // Register copies held by the module, updated only by forwarded writes.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            mode_q <= mmc_pkg::MODE_PASSIVE;
            tpos_q <= '0;
            tvel_q <= '0;
            tacc_q <= '0;
            rel_off_q <= '0;
        end else if (fwd) begin
            if (wr_mode) mode_q <= cw_data_q; // see R1
            if (wr_tpos) tpos_q <= cw_data_q; // see R2
            if (cw_addr == mmc_pkg::REG_REQUESTED_VELOCITY) tvel_q <= cw_data_q;
            if (cw_addr == mmc_pkg::REG_REQUESTED_ACCELERATION) tacc_q <= cw_data_q;
            if (cw_addr == REL_OFFSET_ADDR) rel_off_q <= cw_data_q;
        end
    end

    mmc_cmd_edge u_cmd (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_wr(cw_vld_q && is_mcmd),
        .i_data(cw_data_q),
        .o_fire(cmd_fire),
        .o_cmd(cmd_word),
        .o_armed(cmd_armed)
    );

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_mot_wr_valid <= 1'b0;
            o_mot_wr_addr <= '0;
            o_mot_wr_data <= '0;
        end else begin
            o_mot_wr_valid <= fwd; // see R7
            o_mot_wr_addr <= cw_addr;
            o_mot_wr_data <= cw_data_q;
        end
    end

    // An error drops the drive on the next clock edge, whatever the mode asks for.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_axle_energized <= 1'b0;
            o_error_stop <= 1'b0;
            o_pos_move <= 1'b0;
            o_home_start <= 1'b0;
            o_rel_move <= 1'b0;
            o_save_module <= 1'b0;
            o_save_motor <= 1'b0;
        end else begin
            o_axle_energized <= mode_q != mmc_pkg::MODE_PASSIVE && !err_active; // see R1 see R4
            o_error_stop <= err_active; // see R4
            o_pos_move <= fwd && ((wr_tpos && mode_q == mmc_pkg::MODE_POSITION)
                || (wr_mode && cw_data_q == mmc_pkg::MODE_POSITION)); // see R2
            o_home_start <= home_q == mmc_pkg::HM_IDLE && home_d == mmc_pkg::HM_ACTIVE;
            o_rel_move <= cmd_fire && home_q == mmc_pkg::HM_IDLE
                && (cmd_word == mmc_pkg::CMD_REL_MOVE
                || cmd_word == mmc_pkg::CMD_REL_MOVE_ALT); // see R11
            o_save_module <= i_ac_wr && i_ac_obj == mmc_pkg::OBJ_MODULE_COMMAND
                && i_ac_data == mmc_pkg::SAVE_MODULE_PARAMS; // see R14
            o_save_motor <= i_ac_wr && i_ac_obj == mmc_pkg::OBJ_MODULE_COMMAND
                && i_ac_data == mmc_pkg::SAVE_MOTOR_PARAMS; // see R14
        end
    end

    assign o_actual_mode = mode_q;
    assign o_target_position_value = tpos_q;
    assign o_target_velocity_value = tvel_q;
    assign o_target_acceleration_value = tacc_q;
    assign o_rel_offset = rel_off_q;
    assign o_homing = home_q != mmc_pkg::HM_IDLE;

    // Error cause in the low bits, motion state above it.
    assign status_w = {{(32 - mmc_pkg::BIT_DECELERATING - 1){1'b0}}, i_decelerating,
        i_accelerating, i_in_position,
        {(mmc_pkg::BIT_IN_POSITION - mmc_pkg::ERR_CAUSE_W){1'b0}}, i_err_cause}; // see R5

    // Reads stay live during homing; the mode copy is the actual mode.
    assign rd_val = cr_addr == mmc_pkg::REG_OPERATING_MODE ? mode_q // see R10
        : cr_addr == mmc_pkg::REG_REQUESTED_POSITION ? tpos_q
        : cr_addr == mmc_pkg::REG_REQUESTED_VELOCITY ? tvel_q
        : cr_addr == mmc_pkg::REG_REQUESTED_ACCELERATION ? tacc_q
        : cr_addr == mmc_pkg::REG_ACTUAL_POSITION ? i_actual_position_value // see R2
        : cr_addr == mmc_pkg::REG_ACTUAL_VELOCITY ? i_actual_velocity_value // see R3
        : cr_addr == mmc_pkg::REG_AVERAGE_LOAD ? i_average_load // see R3
        : cr_addr == mmc_pkg::REG_FOLLOWING_ERROR ? i_following_error // see R3
        : cr_addr == mmc_pkg::REG_ERROR_AND_MOTION_STATUS ? status_w // see R4
        : cr_addr == REL_OFFSET_ADDR ? rel_off_q
        : 32'h00000000;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_cr_valid <= 1'b0;
            o_cr_data <= '0;
        end else begin
            o_cr_valid <= cr_vld_q; // see R7 see R15
            o_cr_data <= cr_vld_q ? rd_val : o_cr_data;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_home_done;
        home_q == mmc_pkg::HM_DONE;
    endsequence
    sequence s_release_write;
        wr_mode && !wr_home_code;
    endsequence

    mode_energize_a: assert property ( // see R1
        mode_q == mmc_pkg::MODE_PASSIVE |=> !o_axle_energized)
        else $error("passive mode left the axle energized");
    pos_move_a: assert property ( // see R2
        wr_tpos && !blocked && mode_q == mmc_pkg::MODE_POSITION |=> o_pos_move)
        else $error("position write did not start a move");
    err_stop_a: assert property ( // see R4
        err_active |=> !o_axle_energized && o_error_stop)
        else $error("error did not stop the motor");
    status_bits_a: assert property ( // see R5
        cr_vld_q && cr_addr == mmc_pkg::REG_ERROR_AND_MOTION_STATUS
        |=> o_cr_data[6:4] == $past({i_decelerating, i_accelerating, i_in_position}))
        else $error("motion bits misplaced in status");
    home_block_a: assert property ( // see R7
        home_q == mmc_pkg::HM_ACTIVE && cw_vld_q |=> !o_mot_wr_valid)
        else $error("cyclic write forwarded during homing");
    home_done_a: assert property ( // see R8
        home_q == mmc_pkg::HM_ACTIVE && i_in_position && !in_pos_q
        |=> home_q == mmc_pkg::HM_DONE)
        else $error("homing did not complete on in-position");
    home_resume_a: assert property ( // see R9
        s_home_done ##0 s_release_write |=> home_q == mmc_pkg::HM_IDLE && o_mot_wr_valid)
        else $error("writes not resumed after homing");
    rel_move_a: assert property ( // see R11
        cmd_fire && home_q == mmc_pkg::HM_IDLE && cmd_word == mmc_pkg::CMD_REL_MOVE
        |=> o_rel_move)
        else $error("relative move command ignored");
    save_flash_a: assert property ( // see R14
        i_ac_wr && i_ac_obj == mmc_pkg::OBJ_MODULE_COMMAND
        && i_ac_data == mmc_pkg::SAVE_MOTOR_PARAMS |=> o_save_motor && !o_save_module)
        else $error("motor save request missing");
    read_lat_a: assert property ( // see R15
        i_cr_req |-> ##2 o_cr_valid)
        else $error("cyclic read answer late");
endmodule : mmc_handler

// File: hdl/mmc_map_mem.sv
// Small table of register addresses behind the cyclic word slots.
`timescale 1ns/100ps
module mmc_map_mem #(
    parameter int DEPTH = 8,
    parameter int AW = 20
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Write port
    input wire logic i_wr_en,
    input wire logic [$clog2(DEPTH)-1:0] i_wr_idx,
    input wire logic [AW-1:0] i_wr_addr,
    // Read port
    input wire logic [$clog2(DEPTH)-1:0] i_rd_idx,
    output logic [AW-1:0] o_rd_addr
);
    logic [AW-1:0] mem_q [DEPTH];

    // Each slot is freely mapped to any register address.
    always_ff @(posedge i_clk) begin // see R15
        if (i_wr_en) begin
            mem_q[i_wr_idx] <= i_wr_addr;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_rd_addr <= '0;
        end else begin
            o_rd_addr <= mem_q[i_rd_idx];
        end
    end
endmodule : mmc_map_mem

// File: hdl/mmc_pkg.sv
// Shared constants and types of the motor mode command handler.
package mmc_pkg;

    // Register addresses as seen by the cyclic mapping.
    localparam logic [19:0] REG_OPERATING_MODE = 20'h00002;
    localparam logic [19:0] REG_REQUESTED_POSITION = 20'h00003;
    localparam logic [19:0] REG_REQUESTED_VELOCITY = 20'h00005;
    localparam logic [19:0] REG_REQUESTED_ACCELERATION = 20'h00006;
    localparam logic [19:0] REG_ACTUAL_POSITION = 20'h0000a;
    localparam logic [19:0] REG_ACTUAL_VELOCITY = 20'h0000c;
    localparam logic [19:0] REG_AVERAGE_LOAD = 20'h00010;
    localparam logic [19:0] REG_FOLLOWING_ERROR = 20'h00014;
    localparam logic [19:0] REG_ERROR_AND_MOTION_STATUS = 20'h00023;
    localparam logic [19:0] REG_MODULE_COMMAND = 20'hf0000;

    // Operating mode codes.
    localparam logic [31:0] MODE_PASSIVE = 32'h00000000;
    localparam logic [31:0] MODE_VELOCITY = 32'h00000001;
    localparam logic [31:0] MODE_POSITION = 32'h00000002;
    localparam logic [31:0] MODE_HOME_TORQUE = 32'h0000000c;
    localparam logic [31:0] MODE_HOME_FWD = 32'h0000000d;
    localparam logic [31:0] MODE_HOME_FWD_BWD = 32'h0000000e;
    localparam logic [31:0] MODE_HOME_INDEX = 32'h00000019;
    localparam logic [31:0] MODE_HOME_QUICK_INDEX = 32'h0000001a;

    // Module command words.
    localparam logic [31:0] CMD_CLEAR = 32'h00000000;
    localparam logic [31:0] CMD_REL_MOVE = 32'h010000f1;
    localparam logic [31:0] CMD_REL_MOVE_ALT = 32'h01000071;
    localparam logic [15:0] OBJ_MODULE_COMMAND = 16'h2010;
    localparam logic [31:0] SAVE_MODULE_PARAMS = 32'h00000010;
    localparam logic [31:0] SAVE_MOTOR_PARAMS = 32'h00000110;

    // Error and motion status layout.
    localparam int ERR_CAUSE_W = 4;
    localparam int BIT_IN_POSITION = 4;
    localparam int BIT_ACCELERATING = 5;
    localparam int BIT_DECELERATING = 6;

    // Homing gate states, Gray coded along idle, active, done.
    typedef enum logic [1:0] {
        HM_IDLE = 2'h0,
        HM_ACTIVE = 2'h1,
        HM_DONE = 2'h3
    } mmc_home_type;

endpackage : mmc_pkg

// File: sim/mmc_motor_model.sv
// Behavioural motor that answers forwarded writes with position and motion flags.
`timescale 1ns/100ps
module mmc_motor_model #(
    parameter int RAMP = 20
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Writes from the handler
    input wire logic i_wr_valid,
    input wire logic [19:0] i_wr_addr,
    input wire logic [31:0] i_wr_data,
    input wire logic i_home_start,
    // Motor state
    output logic [31:0] o_position,
    output logic o_in_position,
    output logic o_accelerating,
    output logic o_decelerating
);
    int cnt_q;

    // The position jumps at once; only the flags show the ramp, which keeps the model short.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cnt_q <= 0;
            o_position <= 32'h0;
        end else if (i_home_start) begin
            cnt_q <= RAMP;
            o_position <= 32'h0;
        end else if (i_wr_valid && i_wr_addr == mmc_pkg::REG_REQUESTED_POSITION) begin
            cnt_q <= RAMP;
            o_position <= i_wr_data;
        end else if (cnt_q != 0) begin
            cnt_q <= cnt_q - 1;
        end
    end

    assign o_in_position = (cnt_q == 0);
    assign o_accelerating = (cnt_q > RAMP / 2);
    assign o_decelerating = (cnt_q != 0) && (cnt_q <= RAMP / 2);
endmodule : mmc_motor_model

// File: sim/tb_mmc_handler.sv
// Self-checking testbench of the motor mode command handler.
`timescale 1ns/100ps
module tb_mmc_handler;
    logic i_clk = 1'b0;
    logic rst_n = 1'b0;
    logic map_wr = 1'b0, map_out = 1'b0, cw_valid = 1'b0, cr_req = 1'b0, ac_wr = 1'b0;
    logic [2:0] map_slot = 3'h0, cw_slot = 3'h0, cr_slot = 3'h0;
    logic [19:0] map_addr = 20'h0;
    logic [31:0] cw_data = 32'h0, ac_data = 32'h0, vel = 32'h0, load = 32'h0, ferr = 32'h0;
    logic [15:0] ac_obj = 16'h0;
    logic [3:0] err = 4'h0;
    wire logic cr_valid, mot_wr_valid, home_start, in_pos, accel, decel;
    wire logic [31:0] cr_data, mot_wr_data, position;
    wire logic [19:0] mot_wr_addr;
    int fails = 0;
    int cmp_count = 0;
    logic [31:0] t, h;
    logic [19:0] omap [8] = '{20'h2, 20'h3, 20'h5, 20'h6, 20'hf0000, 20'h7, 20'hc, 20'h10};
    logic [19:0] imap [8] = '{20'h2, 20'ha, 20'hc, 20'h10, 20'h14, 20'h23, 20'hf0000, 20'h3};
    logic [31:0] hm [5] = '{32'hc, 32'hd, 32'he, 32'h19, 32'h1a};
    logic [31:0] md [3] = '{32'h1, 32'h2, 32'h0};

    always #5 i_clk = ~i_clk;

    mmc_handler dut (.i_clk(i_clk), .i_rst_n(rst_n), .i_map_wr(map_wr), .i_map_out(map_out),
        .i_map_slot(map_slot), .i_map_addr(map_addr), .i_cw_valid(cw_valid), .i_cw_slot(cw_slot),
        .i_cw_data(cw_data), .i_cr_req(cr_req), .i_cr_slot(cr_slot), .o_cr_valid(cr_valid),
        .o_cr_data(cr_data), .i_ac_wr(ac_wr), .i_ac_obj(ac_obj), .i_ac_data(ac_data),
        .i_actual_position_value(position), .i_actual_velocity_value(vel),
        .i_average_load(load), .i_following_error(ferr), .i_err_cause(err),
        .i_in_position(in_pos), .i_accelerating(accel), .i_decelerating(decel),
        .o_mot_wr_valid(mot_wr_valid), .o_mot_wr_addr(mot_wr_addr), .o_mot_wr_data(mot_wr_data),
        .o_axle_energized(), .o_error_stop(), .o_actual_mode(), .o_target_position_value(),
        .o_target_velocity_value(), .o_target_acceleration_value(), .o_pos_move(),
        .o_home_start(home_start), .o_homing(), .o_rel_move(), .o_rel_offset(),
        .o_save_module(), .o_save_motor());

    mmc_motor_model motor (.i_clk(i_clk), .i_rst_n(rst_n), .i_wr_valid(mot_wr_valid),
        .i_wr_addr(mot_wr_addr), .i_wr_data(mot_wr_data), .i_home_start(home_start),
        .o_position(position), .o_in_position(in_pos), .o_accelerating(accel),
        .o_decelerating(decel));

    function automatic logic [31:0] st(input logic [3:0] e, input logic i, a, d);
        return {25'h0, d, a, i, e};
    endfunction : st

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic test_done();
        if (fails == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    task automatic map(input logic o, input logic [2:0] s, input logic [19:0] a);
        @(posedge i_clk);
        map_wr <= 1'b1;
        map_out <= o;
        map_slot <= s;
        map_addr <= a;
        @(posedge i_clk);
        map_wr <= 1'b0;
    endtask : map

    // The answer is registered one edge after the taking edge; valid stands one cycle only, the data word holds until the next read.
    task automatic cr(input logic [2:0] s, input logic [31:0] e);
        @(posedge i_clk);
        cr_req <= 1'b1;
        cr_slot <= s;
        @(posedge i_clk);
        cr_req <= 1'b0;
        @(posedge i_clk);
        #1;
        chk(cr_valid, 1'b1);
        chk(cr_data, e);
    endtask : cr

    task automatic cw(input logic [2:0] s, input logic [31:0] d, input logic f,
                      input logic [19:0] a);
        @(posedge i_clk);
        cw_valid <= 1'b1;
        cw_slot <= s;
        cw_data <= d;
        @(posedge i_clk);
        cw_valid <= 1'b0;
        @(posedge i_clk);
        #1;
        chk(mot_wr_valid, f);
        if (f) begin
            chk(mot_wr_addr, a);
            chk(mot_wr_data, d);
        end
    endtask : cw

    task automatic cmd(input logic [31:0] d, input logic e, input logic [31:0] o);
        cw(3'h4, d, 1'b0, 20'h0);
        @(posedge i_clk);
        #1;
        chk(dut.o_rel_move, e);
        if (e) begin
            chk(dut.o_rel_offset, o);
        end
    endtask : cmd

    task automatic ac(input logic [15:0] ob, input logic [31:0] d, input logic em, eo);
        @(posedge i_clk);
        ac_wr <= 1'b1;
        ac_obj <= ob;
        ac_data <= d;
        @(posedge i_clk);
        ac_wr <= 1'b0;
        #1;
        chk(dut.o_save_module, em);
        chk(dut.o_save_motor, eo);
    endtask : ac

    initial begin
        #200000;
        fails++;
        test_done();
    end

    initial begin
        void'($urandom(96590));
        repeat (6) @(posedge i_clk);
        rst_n <= 1'b1;
        #1;
        chk(dut.o_axle_energized, 1'b0);
        for (int i = 0; i < 8; i++) begin
            map(1'b1, i[2:0], omap[i]);
            map(1'b0, i[2:0], imap[i]);
        end
        for (int i = 0; i < 3; i++) begin
            @(posedge i_clk);
            vel <= $urandom;
            load <= $urandom;
            ferr <= $urandom;
            #1;
            cr(3'h2, vel);
            cr(3'h3, load);
            cr(3'h4, ferr);
        end
        foreach (md[i]) begin
            cw(3'h0, md[i], 1'b1, 20'h2);
            chk(dut.o_actual_mode, md[i]);
            @(posedge i_clk);
            #1;
            chk(dut.o_axle_energized, md[i] != 32'h0);
            cr(3'h0, md[i]);
        end
        cw(3'h0, mmc_pkg::MODE_POSITION, 1'b1, 20'h2);
        t = $urandom;
        cw(3'h2, t ^ 32'h1, 1'b1, 20'h5);
        chk(dut.o_target_velocity_value, t ^ 32'h1);
        cw(3'h3, t ^ 32'h2, 1'b1, 20'h6);
        chk(dut.o_target_acceleration_value, t ^ 32'h2);
        cw(3'h1, t, 1'b1, 20'h3);
        chk(dut.o_pos_move, 1'b1);
        chk(dut.o_target_position_value, t);
        cr(3'h5, st(4'h0, 1'b0, 1'b1, 1'b0));
        repeat (25) @(posedge i_clk);
        cr(3'h1, t);
        cr(3'h5, st(4'h0, 1'b1, 1'b0, 1'b0));
        @(posedge i_clk);
        err <= 4'($urandom_range(15, 1));
        repeat (2) @(posedge i_clk);
        #1;
        chk(dut.o_error_stop, 1'b1);
        chk(dut.o_axle_energized, 1'b0);
        cr(3'h5, st(err, 1'b1, 1'b0, 1'b0));
        @(posedge i_clk);
        err <= 4'h0;
        repeat (2) @(posedge i_clk);
        #1;
        chk(dut.o_axle_energized, 1'b1);
        foreach (hm[i]) begin
            cw(3'h0, hm[i], 1'b1, 20'h2);
            chk(dut.o_home_start, 1'b1);
            chk(dut.o_homing, 1'b1);
            cw(3'h2, $urandom, 1'b0, 20'h5);
            cr(3'h1, 32'h0);
            repeat (25) @(posedge i_clk);
            cr(3'h5, st(4'h0, 1'b1, 1'b0, 1'b0));
            cw(3'h0, mmc_pkg::MODE_POSITION, 1'b1, 20'h2);
            chk(dut.o_homing, 1'b0);
            h = $urandom;
            cw(3'h2, h, 1'b1, 20'h5);
        end
        // The second command word only fires if the zero write of the first round re-armed.
        foreach (hm[i]) begin
            if (i < 2) begin
                t = $urandom;
                cw(3'h5, t, 1'b1, 20'h7);
                repeat (2) @(posedge i_clk);
                h = (i == 0) ? mmc_pkg::CMD_REL_MOVE : mmc_pkg::CMD_REL_MOVE_ALT;
                cmd(h, 1'b1, t);
                cmd(h, 1'b0, t);
                cmd(32'h0, 1'b0, t);
            end
        end
        cr(3'h6, 32'h0);
        ac(16'h2010, 32'h10, 1'b1, 1'b0);
        ac(16'h2010, 32'h110, 1'b0, 1'b1);
        ac(16'h2011, 32'h10, 1'b0, 1'b0);
        ac(16'h2010, 32'h11, 1'b0, 1'b0);
        test_done();
    end
endmodule : tb_mmc_handler
